// >>> acr_pkg.sv
// Constants and types for the converter control register block
package acr_pkg;
   // ==========================================================
   // Widths and field positions
   localparam int CTRL_W          = 14;
   localparam int WORD_W          = 16;
   localparam int POS_INPUT_CFG   = 13;
   localparam int POS_CHAN_HI     = 12;
   localparam int POS_CHAN_LO     = 10;
   localparam int POS_POWER_HI    = 9;
   localparam int POS_POWER_LO    = 8;
   localparam int POS_READ_HI     = 7;
   localparam int POS_READ_LO     = 6;
   localparam int POS_RANGE_MODE  = 5;
   localparam int POS_CONV_GO     = 4;
   localparam int POS_CAL_CLASS   = 3;
   localparam int POS_CAL_PICK_HI = 2;
   localparam int POS_CAL_PICK_LO = 1;
   localparam int POS_CAL_GO      = 0;
   // ==========================================================
   // Addresses and reset values
   localparam logic [1:0] ADDR_NONE = 2'h0;
   localparam logic [1:0] ADDR_TEST = 2'h1;
   localparam logic [1:0] ADDR_CAL  = 2'h2;
   localparam logic [1:0] ADDR_CTRL = 2'h3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
   localparam logic [1:0] RD_DATA   = 2'h0;
   localparam logic [1:0] RD_TEST   = 2'h1;
   localparam logic [1:0] RD_CAL    = 2'h2;
   localparam logic [1:0] RD_STATUS = 2'h3;
   // Negative input codes
   localparam logic [3:0] NEG_GROUND = 4'hF;
   localparam logic [3:0] NEG_EIGHTH = 4'h7;
   // ==========================================================
   // Byte assembly states
   typedef enum logic [1:0] {
      ACR_LOW  = 2'b01,
      ACR_HIGH = 2'b10
   } acr_byte_t;
endpackage

// >>> acr_word_if.sv
// Interface carrying an assembled host word to the control register
`timescale 1ns/10ps
interface acr_word_if;
   logic        valid;
   logic [15:0] word;
   modport source (output valid, output word);
   modport sink   (input valid, input word);
endinterface

// >>> acr_word_assembler.sv
// Assembles host writes in word or byte mode into a 16-bit word
`timescale 1ns/10ps
module acr_word_assembler
   import acr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       writeStrobe,
   input  wire logic       wordMode,
   input  wire logic [15:0] dataIn,
   acr_word_if.source      out
);
   acr_byte_t   state;
   acr_byte_t   next_state;
   logic [7:0]  lowByte;
   logic [7:0]  next_lowByte;
   logic        valid;
   logic        next_valid;
   logic [15:0] word;
   logic [15:0] next_word;

   // ==========================================================
   // Next values: byte mode waits for the high byte
   always_comb begin
      next_state   = state;
      next_lowByte = lowByte;
      next_valid   = 1'b0;
      next_word    = word;
      if (writeStrobe) begin
         if (wordMode) begin
            next_valid = 1'b1;
            next_word  = dataIn;
            next_state = ACR_LOW;
         end else begin
            case (state)
               ACR_LOW: begin
                  next_lowByte = dataIn[7:0];
                  next_state   = ACR_HIGH;
               end
               ACR_HIGH: begin
                  next_valid = 1'b1;
                  next_word  = {dataIn[7:0], lowByte};
                  next_state = ACR_LOW;
               end
               default: next_state = ACR_LOW;
            endcase
         end
      end
   end

   // Registers only
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state   <= ACR_LOW;
         lowByte <= 8'h00;
         valid   <= 1'b0;
         word    <= 16'h0000;
      end else begin
         state   <= next_state;
         lowByte <= next_lowByte;
         valid   <= next_valid;
         word    <= next_word;
      end
   end

   assign out.valid = valid;
   assign out.word  = word;

   a_byte_pair : assert property (@(posedge clock) disable iff (!reset_n)
      (writeStrobe && !wordMode && state == ACR_LOW) |=> !valid)
      else $error("low byte alone produced a word");
endmodule

// >>> adc_control_register.sv
// Write-only control register of the eight-channel converter
`timescale 1ns/10ps
module adc_control_register
   import acr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        writeStrobe,
   input  wire logic        wordMode,
   input  wire logic [15:0] dataIn,
   input  wire logic        sleep_n,
   input  wire logic        conversionDone,
   input  wire logic        calibrationStarted,
   output logic             inputConfigSelect,
   output logic [2:0]       channelSel,
   output logic [3:0]       positiveInput,
   output logic [3:0]       negativeInput,
   output logic             bipolarRange,
   output logic [1:0]       powerSel,
   output logic [2:0]       powerMode,
   output logic [1:0]       readTarget,
   output logic             softConversionGo,
   output logic             conversionLaunch,
   output logic             calClassSelect,
   output logic [1:0]       calPick,
   output logic             calGo,
   output logic [2:0]       calSequence,
   output logic             calSequenceValid,
   output logic [1:0]       coeffPointer,
   output logic             testWrite,
   output logic             calWrite,
   output logic [13:0]      writeData
);
   acr_word_if wordBus ();

   logic [CTRL_W-1:0] ctrl;
   logic [CTRL_W-1:0] next_ctrl;
   logic              launch;
   logic              next_launch;
   logic              tw;
   logic              next_tw;
   logic              cw;
   logic              next_cw;
   logic [13:0]       wd;
   logic [13:0]       next_wd;
   logic [1:0]        addr;

   // ==========================================================
   // Host word assembly
   acr_word_assembler u_asm (
      .clock       (clock),
      .reset_n     (reset_n),
      .writeStrobe (writeStrobe),
      .wordMode    (wordMode),
      .dataIn      (dataIn),
      .out         (wordBus.source)
   );

   assign addr = wordBus.word[WORD_W-1:WORD_W-2];

   // Map a differential pair or single-ended select onto input numbers
   function automatic logic [3:0] pos_input(input logic sgl, input logic [2:0] ch);
      if (sgl) begin
         pos_input = {1'b0, ch[1:0], ch[2]};
      end else begin
         pos_input = {1'b0, ch[1:0], 1'b0};
      end
   endfunction

   // ==========================================================
   // Next control value
   always_comb begin
      next_ctrl   = ctrl;
      next_launch = 1'b0;
      next_tw     = 1'b0;
      next_cw     = 1'b0;
      next_wd     = wd;
      // Completion and consumption clear the one-shot bits
      if (conversionDone) begin
         next_ctrl[POS_CONV_GO] = 1'b0;
      end
      if (calibrationStarted) begin
         next_ctrl[POS_CAL_GO] = 1'b0;
      end
      if (wordBus.valid) begin
         next_wd = wordBus.word[CTRL_W-1:0];
         // Only the all-ones address reaches control; others leave it alone
         if (addr == ADDR_CTRL) begin
            next_ctrl   = wordBus.word[CTRL_W-1:0];
            next_launch = wordBus.word[POS_CONV_GO];
         end else begin
            next_tw = (addr == ADDR_TEST);
            next_cw = (addr == ADDR_CAL);
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl   <= CTRL_RESET;
         launch <= 1'b0;
         tw     <= 1'b0;
         cw     <= 1'b0;
         wd     <= 14'h0000;
      end else begin
         ctrl   <= next_ctrl;
         launch <= next_launch;
         tw     <= next_tw;
         cw     <= next_cw;
         wd     <= next_wd;
      end
   end

   // ==========================================================
   // Field decode; no read path exposes ctrl itself
   assign inputConfigSelect = ctrl[POS_INPUT_CFG];
   assign channelSel        = ctrl[POS_CHAN_HI:POS_CHAN_LO];
   assign positiveInput     = pos_input(inputConfigSelect, channelSel);
   // Single-ended: range bit picks the negative input, range stays unipolar
   assign negativeInput     = inputConfigSelect ?
                              (ctrl[POS_RANGE_MODE] ? NEG_EIGHTH : NEG_GROUND) :
                              (positiveInput + 4'h1);
   assign bipolarRange      = !inputConfigSelect && ctrl[POS_RANGE_MODE];
   assign powerSel          = ctrl[POS_POWER_HI:POS_POWER_LO];
   assign powerMode         = {powerSel, sleep_n};
   assign readTarget        = ctrl[POS_READ_HI:POS_READ_LO];
   assign softConversionGo  = ctrl[POS_CONV_GO];
   assign conversionLaunch  = launch;
   assign calClassSelect    = ctrl[POS_CAL_CLASS];
   assign calPick           = ctrl[POS_CAL_PICK_HI:POS_CAL_PICK_LO];
   assign calGo             = ctrl[POS_CAL_GO];
   assign calSequence       = {calClassSelect, calPick};
   assign calSequenceValid  = calGo;
   assign coeffPointer      = calGo ? 2'h0 : calPick;
   assign testWrite         = tw;
   assign calWrite          = cw;
   assign writeData         = wd;

   // ==========================================================
   // Checks
   a_ctrl_addr_only : assert property (@(posedge clock) disable iff (!reset_n)
      (wordBus.valid && addr != ADDR_CTRL && !conversionDone && !calibrationStarted)
      |=> $stable(ctrl))
      else $error("control changed on foreign address");
   a_ctrl_write : assert property (@(posedge clock) disable iff (!reset_n)
      (wordBus.valid && addr == ADDR_CTRL) |=> ctrl == $past(wordBus.word[13:0]))
      else $error("control write not stored");
   a_conv_clear : assert property (@(posedge clock) disable iff (!reset_n)
      (conversionDone && !(wordBus.valid && addr == ADDR_CTRL)) |=> !softConversionGo)
      else $error("conversion bit not cleared");
   a_conv_launch : assert property (@(posedge clock) disable iff (!reset_n)
      conversionLaunch |-> softConversionGo
      ##1 (!conversionLaunch || $past(wordBus.valid && addr == ADDR_CTRL)))
      else $error("launch not single");
   a_cal_consume : assert property (@(posedge clock) disable iff (!reset_n)
      (calibrationStarted && !(wordBus.valid && addr == ADDR_CTRL)) |=> !calGo)
      else $error("calibration request not consumed");
   a_bipolar_diff : assert property (@(posedge clock) disable iff (!reset_n)
      bipolarRange |-> !inputConfigSelect && ctrl[5])
      else $error("bipolar in single-ended");
   a_neg_single : assert property (@(posedge clock) disable iff (!reset_n)
      inputConfigSelect |-> (negativeInput == (ctrl[5] ? NEG_EIGHTH : NEG_GROUND)))
      else $error("wrong negative input");
   a_pointer_mode : assert property (@(posedge clock) disable iff (!reset_n)
      !calGo |-> coeffPointer == ctrl[2:1])
      else $error("pointer decode wrong");
   a_read_persist : assert property (@(posedge clock) disable iff (!reset_n)
      !(wordBus.valid && addr == ADDR_CTRL) |=> $stable(readTarget))
      else $error("read select drifted");
endmodule

// >>> acr_host_model.sv
// Host processor model that writes words or byte pairs to the control port
`timescale 1ns/10ps
module acr_host_model (
   input  wire logic        clock,
   output logic             writeStrobe,
   output logic             wordMode,
   output logic [15:0]      dataIn
);
   // ==========================================================
   // Idle bus after power-up
   initial begin
      writeStrobe = 1'b0;
      wordMode    = 1'b1;
      dataIn      = 16'h0000;
   end
   // ==========================================================
   // One host write, address in the top two bits
   task automatic send(input logic [15:0] word, input logic byteWide);
      @(negedge clock);
      wordMode    = !byteWide;
      writeStrobe = 1'b1;
      dataIn      = byteWide ? {8'hA5, word[7:0]} : word;
      if (byteWide) begin
         @(negedge clock);
         dataIn = {8'h5A, word[15:8]};
      end
      @(negedge clock);
      writeStrobe = 1'b0;
      dataIn      = ~dataIn; // Released bus has no pull, so never the last value
   endtask
endmodule

// >>> adc_control_register_bench.sv
// Self-checking bench of the converter control register
`timescale 1ns/10ps
module adc_control_register_bench
   import acr_pkg::*;
;
   logic clock = 1'b0, reset_n = 1'b0, sleep_n = 1'b1;
   logic conversionDone = 1'b0, calibrationStarted = 1'b0;
   logic writeStrobe, wordMode;
   logic [15:0] dataIn;
   logic inputConfigSelect, bipolarRange, softConversionGo, conversionLaunch;
   logic calClassSelect, calGo, calSequenceValid, testWrite, calWrite;
   logic [2:0] channelSel, powerMode, calSequence;
   logic [3:0] positiveInput, negativeInput;
   logic [1:0] powerSel, readTarget, calPick, coeffPointer;
   logic [13:0] writeData, expCtrl = 14'h0000, v;
   logic [30:0] fieldQ[$];
   logic [16:0] pulseQ[$];
   int miscompares = 0, comparisons = 0, cycles = 0;
   event checkNow;
   // ==========================================================
   // Clock, partner and design
   always #20 clock = ~clock;
   acr_host_model acr_host_model_inst (.clock(clock), .writeStrobe(writeStrobe),
      .wordMode(wordMode), .dataIn(dataIn));
   adc_control_register adc_control_register_inst (.clock(clock), .reset_n(reset_n),
      .writeStrobe(writeStrobe), .wordMode(wordMode), .dataIn(dataIn), .sleep_n(sleep_n),
      .conversionDone(conversionDone), .calibrationStarted(calibrationStarted),
      .inputConfigSelect(inputConfigSelect), .channelSel(channelSel),
      .positiveInput(positiveInput), .negativeInput(negativeInput),
      .bipolarRange(bipolarRange), .powerSel(powerSel), .powerMode(powerMode),
      .readTarget(readTarget), .softConversionGo(softConversionGo),
      .conversionLaunch(conversionLaunch), .calClassSelect(calClassSelect),
      .calPick(calPick), .calGo(calGo), .calSequence(calSequence),
      .calSequenceValid(calSequenceValid), .coeffPointer(coeffPointer),
      .testWrite(testWrite), .calWrite(calWrite), .writeData(writeData));
   // ==========================================================
   // Expected decode of a control value and sleep level
   function automatic logic [30:0] expect_outputs(input logic [13:0] c, input logic s);
      logic [3:0] pos;
      logic [3:0] neg;
      pos = c[13] ? {1'b0, c[11], c[10], c[12]} : {1'b0, c[11:10], 1'b0};
      neg = c[13] ? (c[5] ? NEG_EIGHTH : NEG_GROUND) : pos + 4'h1;
      return {c[13], c[12:10], pos, neg, !c[13] && c[5], c[9:8], c[9:8], s, c[7:6], c[4],
              c[3], c[2:1], c[0], c[3:1], c[0], c[0] ? 2'h0 : c[2:1]};
   endfunction
   // ==========================================================
   // Compare tasks and verdict
   task automatic compare_fields(input logic [30:0] e, input logic [30:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected decoded fields expected %h seen %h", e, s);
      end
   endtask
   task automatic compare_pulse(input logic [16:0] e, input logic [16:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected write pulse expected %h seen %h", e, s);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // Watchers take the oldest note when a result appears
   always begin
      @(checkNow);
      compare_fields(fieldQ.pop_front(), {inputConfigSelect, channelSel, positiveInput,
         negativeInput, bipolarRange, powerSel, powerMode, readTarget, softConversionGo,
         calClassSelect, calPick, calGo, calSequence, calSequenceValid, coeffPointer});
   end
   always @(negedge clock) begin
      if (reset_n && (conversionLaunch === 1'b1 || testWrite === 1'b1 || calWrite === 1'b1))
         compare_pulse(pulseQ.size() ? pulseQ.pop_front() : 17'h00000,
                       {conversionLaunch, testWrite, calWrite, writeData});
   end
   // Hang guard, far above the expected run of a few hundred cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ==========================================================
   // Driver tasks, outputs settle two cycles after the strobe
   task automatic settle_check;
      repeat (2) @(negedge clock);
      fieldQ.push_back(expect_outputs(expCtrl, sleep_n));
      -> checkNow;
      @(negedge clock);
   endtask
   task automatic write_any(input logic [1:0] a, input logic [13:0] d, input logic bw);
      if (a == ADDR_CTRL) expCtrl = d;
      if (a == ADDR_CTRL && d[4]) pulseQ.push_back({3'h4, d});
      if (a == ADDR_TEST || a == ADDR_CAL) pulseQ.push_back({1'b0, a == ADDR_TEST, a == ADDR_CAL, d});
      acr_host_model_inst.send({a, d}, bw);
      settle_check();
   endtask
   task automatic clear_pulse(input logic conv);
      @(negedge clock);
      conversionDone     = conv;
      calibrationStarted = !conv;
      @(negedge clock);
      conversionDone     = 1'b0;
      calibrationStarted = 1'b0;
      if (conv) expCtrl[4] = 1'b0;
      else expCtrl[0] = 1'b0;
      settle_check();
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(43));
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      settle_check();
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         v = 14'($urandom());
         v[3:1] = i[2:0];
         v[7:6] = i[1:0];
         v[13] = i[3];
         if (!v[13]) v[12] = 1'b0;
         sleep_n = 1'($urandom());
         write_any(ADDR_CTRL, v, i[4]);
      end
      $display("test field decode done");
      write_any(ADDR_CTRL, 14'h0010, 1'b0);
      clear_pulse(1'b1);
      $display("test conversion done");
      write_any(ADDR_CTRL, 14'h2BCD, 1'b1);
      clear_pulse(1'b0);
      $display("test calibration done");
      // Reset in mid-run must drop the nonzero control value
      reset_n = 1'b0;
      expCtrl = CTRL_RESET;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      settle_check();
      $display("test second reset done");
      for (int a = 0; a < 3; a++) write_any(2'(a), 14'($urandom()), a[0]);
      sleep_n = ~sleep_n;
      settle_check();
      $display("test addressing done");
      // Every noted pulse must have appeared
      compare_pulse(17'h00000, 17'(pulseQ.size()));
      give_verdict();
   end
endmodule
